// ==== hdl/pss_defines.svh ====
/*
 Constants of the program sequencer: register indices, vectors, widths.
 Assumes inclusion by the package, the sequencer, the memory model and the bench.
*/
// Contract
// - Four phases make one instruction cycle
// - Fetch overlaps execute; transfers take two
// - Counter is twelve bits, 4096 words
// - Counter advances by one per fetch
// - True skip discards fetched word
// - Low byte write jumps within page
// - Every control transfer adds dummy cycle
// - Reset clears counter to zero
// - Line a interrupt vectors to 004
// - Line b interrupt vectors to 008
// - Timer one overflow vectors to 00C
// - Timer two overflow vectors to 010
// - Time base interrupt vectors to 014
// - Real time clock vectors to 018
// - Jump, call, return load twelve bits
// - Table address from pointer and page
// - Table high gets upper seven bits
// - Table reads take two cycles
// - Six level hidden return stack
// - Reset empties the stack
// - Full stack holds interrupts pending
// - Call on full stack drops oldest
// - Acknowledge clears global interrupt enable
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_PC_W 12
`define PSS_WORD_W 15
`define PSS_NUM_IRQ 6
`define PSS_STACK_LEVELS 3'd6
`define PSS_PC_RESET 12'h000
`define PSS_LAST_PAGE 4'hf
`define PSS_IDX_PCL 12'h006
`define PSS_IDX_TBLPTR 12'h007
`define PSS_IDX_TBLHI 12'h008
`define PSS_IDX_STAT 12'h009
`define PSS_ADDR_PCL (`PSS_IDX_PCL << 2)
`define PSS_ADDR_TBLPTR (`PSS_IDX_TBLPTR << 2)
`define PSS_ADDR_TBLHI (`PSS_IDX_TBLHI << 2)
`define PSS_ADDR_STAT (`PSS_IDX_STAT << 2)
`define PSS_TBLPTR_RESET 8'h00
`define PSS_VEC_A 12'h004
`define PSS_VEC_B 12'h008
`define PSS_VEC_T0 12'h00c
`define PSS_VEC_T1 12'h010
`define PSS_VEC_TB 12'h014
`define PSS_VEC_RTC 12'h018
`endif

// ==== hdl/pss_pkg.sv ====
/*
 Types of the program sequencer.
 Assumes the defines header sits beside it.
*/
`include "pss_defines.svh"
package pss_pkg;
    // Instruction phase, one-hot
    typedef enum logic [3:0] {
        PSS_PH1 = 4'b0001,
        PSS_PH2 = 4'b0010,
        PSS_PH3 = 4'b0100,
        PSS_PH4 = 4'b1000
    } pss_phase_t;
    // Sequencing class of the executing instruction, one-hot
    typedef enum logic [7:0] {
        PSS_OP_NORMAL = 8'h01,
        PSS_OP_SKIP = 8'h02,
        PSS_OP_JUMP = 8'h04,
        PSS_OP_CALL = 8'h08,
        PSS_OP_RET = 8'h10,
        PSS_OP_INTERRUPT_RETURN = 8'h20,
        PSS_OP_TABC = 8'h40,
        PSS_OP_TABL = 8'h80
    } pss_op_t;
    // Decoder command for the instruction in execute
    typedef struct packed {
        pss_op_t op;
        logic [`PSS_PC_W-1:0] target;
    } pss_cmd_t;
endpackage

// ==== hdl/pss_sequencer.sv ====
/*
 Program sequencer: phase divider, fetch/execute pipeline, program
 counter, six-level return stack, table reads, APB register slave.
 Assumes a program memory that answers prog_addr_q within the cycle,
 a decoder that drives cmd from instr_q on the same clock, and
 interrupt requests already gated by their own enables.
*/
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_sequencer
    import pss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Program memory
    output logic [`PSS_PC_W-1:0] prog_addr_q,
    input wire logic [`PSS_WORD_W-1:0] prog_data,
    // Decoder side
    output logic [`PSS_WORD_W-1:0] instr_q,
    output logic exec_valid_q,
    input wire pss_cmd_t cmd,
    output pss_phase_t phase_q,
    output logic [7:0] tab_low_q,
    output logic tab_low_stb_q,
    // Interrupts
    input wire logic [`PSS_NUM_IRQ-1:0] irq_pending,
    input wire logic global_irq_enable,
    output logic [`PSS_NUM_IRQ-1:0] irq_ack_q,
    output logic gie_clear_q
);

    // ----------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------
    logic [`PSS_PC_W-1:0] pc_q; // Address being fetched
    logic [`PSS_PC_W-1:0] pc_d;
    logic [`PSS_PC_W-1:0] stack_q [0:5]; // Hidden return stack
    logic [2:0] sp_q; // Entries in use, readable in the status register
    logic fetched_ok_q; // Fetched word is real, not dummy
    logic stall_q; // Table read second cycle
    logic [`PSS_PC_W-1:0] tab_addr_q;
    logic [6:0] tbl_high_q;
    logic [7:0] tbl_ptr_q;
    logic pcl_pend_q; // Low byte write awaits cycle end
    logic [7:0] pcl_data_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic cyc_end; // Last enabled edge of the cycle
    logic run; // Current instruction executes now
    logic stack_full;
    logic take_irq;
    logic push;
    logic pop;
    logic flush; // Fetched word becomes a dummy
    logic start_tab;
    logic [`PSS_NUM_IRQ-1:0] irq_sel;
    logic [`PSS_PC_W-1:0] vector;
    logic [`PSS_PC_W-1:0] pop_val;
    logic apb_wr;
    logic pcl_wr;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ----------------------------------------------------------
    // Phase divider
    // ----------------------------------------------------------
    // Four non-overlapping phases, rotating on enabled edges
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            phase_q <= PSS_PH1;
        end else if (clk_en) begin
            case (phase_q)
                PSS_PH1: phase_q <= PSS_PH2;
                PSS_PH2: phase_q <= PSS_PH3;
                PSS_PH3: phase_q <= PSS_PH4;
                PSS_PH4: phase_q <= PSS_PH1;
                default: phase_q <= PSS_PH1;
            endcase
        end
    end

    assign cyc_end = clk_en && (phase_q == PSS_PH4);
    assign stack_full = (sp_q == `PSS_STACK_LEVELS);
    assign run = exec_valid_q;

    // ----------------------------------------------------------
    // Interrupt priority and vector
    // ----------------------------------------------------------
    // Lowest set bit wins; it owns the lowest vector
    always_comb begin
        irq_sel = '0;
        vector = `PSS_VEC_RTC;
        if (irq_pending[0]) begin
            irq_sel = 6'b000001;
            vector = `PSS_VEC_A;
        end else if (irq_pending[1]) begin
            irq_sel = 6'b000010;
            vector = `PSS_VEC_B;
        end else if (irq_pending[2]) begin
            irq_sel = 6'b000100;
            vector = `PSS_VEC_T0;
        end else if (irq_pending[3]) begin
            irq_sel = 6'b001000;
            vector = `PSS_VEC_T1;
        end else if (irq_pending[4]) begin
            irq_sel = 6'b010000;
            vector = `PSS_VEC_TB;
        end else if (irq_pending[5]) begin
            irq_sel = 6'b100000;
        end
    end

    // Top entry; an empty stack returns entry zero
    assign pop_val = (sp_q == 3'd0) ? stack_q[0] : stack_q[sp_q - 3'd1];

    // ----------------------------------------------------------
    // Next program counter
    // ----------------------------------------------------------
    // Priority: table stall, low byte write, executing transfer, interrupt, fetch
    always_comb begin
        pc_d = pc_q + 12'h001;
        push = 1'b0;
        pop = 1'b0;
        flush = 1'b0;
        take_irq = 1'b0;
        start_tab = 1'b0;
        if (stall_q) begin
            // Memory is busy with the table word; no fetch
            pc_d = pc_q;
        end else if (pcl_pend_q) begin
            // Short jump inside the current page
            pc_d = {pc_q[11:8], pcl_data_q};
            flush = 1'b1;
        end else if (run && cmd.op == PSS_OP_SKIP) begin
            flush = 1'b1;
        end else if (run && (cmd.op == PSS_OP_JUMP || cmd.op == PSS_OP_CALL)) begin
            pc_d = cmd.target;
            flush = 1'b1;
            push = (cmd.op == PSS_OP_CALL);
        end else if (run && (cmd.op == PSS_OP_RET || cmd.op == PSS_OP_INTERRUPT_RETURN)) begin
            pc_d = pop_val;
            pop = 1'b1;
            flush = 1'b1;
        end else if (run && (cmd.op == PSS_OP_TABC || cmd.op == PSS_OP_TABL)) begin
            start_tab = 1'b1;
        end else if (|irq_pending && global_irq_enable && !stack_full) begin
            // Full stack leaves the request pending
            take_irq = 1'b1;
            pc_d = vector;
            push = 1'b1;
            flush = 1'b1;
        end
    end

    // ----------------------------------------------------------
    // Program counter and fetch pipeline
    // ----------------------------------------------------------
    // Counter and memory address move only at cycle end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pc_q <= `PSS_PC_RESET;
            prog_addr_q <= `PSS_PC_RESET;
        end else if (cyc_end) begin
            pc_q <= pc_d;
            // A table read borrows the memory for one cycle
            prog_addr_q <= start_tab ? tab_addr_q : pc_d;
        end
    end

    // Fetched word latches; dummy marking on flushes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            instr_q <= '0;
            fetched_ok_q <= 1'b0;
            exec_valid_q <= 1'b0;
        end else if (cyc_end) begin
            if (!stall_q) begin
                instr_q <= prog_data;
                fetched_ok_q <= !flush;
                exec_valid_q <= !flush && !start_tab;
            end else begin
                // Held word executes after the table cycle
                exec_valid_q <= fetched_ok_q;
            end
        end
    end

    // ----------------------------------------------------------
    // Table reads
    // ----------------------------------------------------------
    // Table address built from pointer and page bits
    always_comb begin
        tab_addr_q = {pc_q[11:8], tbl_ptr_q};
        if (cmd.op == PSS_OP_TABL) begin
            tab_addr_q = {`PSS_LAST_PAGE, tbl_ptr_q};
        end
    end

    // Second cycle captures the word
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stall_q <= 1'b0;
            tbl_high_q <= '0;
            tab_low_q <= '0;
            tab_low_stb_q <= 1'b0;
        end else if (clk_en) begin
            tab_low_stb_q <= 1'b0;
            if (cyc_end) begin
                stall_q <= start_tab;
                if (stall_q) begin
                    tab_low_q <= prog_data[7:0];
                    tab_low_stb_q <= 1'b1;
                    tbl_high_q <= prog_data[14:8];
                end
            end
        end
    end

    // ----------------------------------------------------------
    // Return stack
    // ----------------------------------------------------------
    // Depth counter; a full push keeps depth at six
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sp_q <= 3'd0;
        end else if (cyc_end) begin
            if (push && !stack_full) begin
                sp_q <= sp_q + 3'd1;
            end else if (pop && sp_q != 3'd0) begin
                sp_q <= sp_q - 3'd1;
            end
        end
    end

    // Per-entry storage; full pushes shift out the oldest
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_stk
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    stack_q[g] <= '0;
                end else if (cyc_end && push) begin
                    if (stack_full) begin
                        if (g == 5) begin
                            stack_q[g] <= pc_q;
                        end else begin
                            stack_q[g] <= stack_q[(g + 1) % 6];
                        end
                    end else if (sp_q == 3'(g)) begin
                        stack_q[g] <= pc_q;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------
    // Interrupt acknowledge
    // ----------------------------------------------------------
    // One pulse per entry; the enable is cleared outside
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_ack_q <= '0;
            gie_clear_q <= 1'b0;
        end else if (clk_en) begin
            irq_ack_q <= (cyc_end && take_irq) ? irq_sel : '0;
            gie_clear_q <= cyc_end && take_irq;
        end
    end

    // ----------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------
    // No wait state: ready rises in the first access cycle
    assign apb_wr = psel && penable && pready_q && pwrite;
    assign pcl_wr = apb_wr && !pslverr_q && paddr == `PSS_ADDR_PCL;

    // Read data and decode captured in setup
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (clk_en) begin
            pready_q <= psel && !penable;
            pslverr_q <= 1'b0;
            if (psel && !penable) begin
                prdata_q <= '0;
                case (paddr)
                    `PSS_ADDR_PCL: prdata_q <= {24'h000000, pc_q[7:0]};
                    `PSS_ADDR_TBLPTR: prdata_q <= {24'h000000, tbl_ptr_q};
                    `PSS_ADDR_TBLHI: prdata_q <= {25'h0000000, tbl_high_q};
                    `PSS_ADDR_STAT: prdata_q <= {27'h0000000, stall_q, stack_full, sp_q};
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // Table pointer is plain storage
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tbl_ptr_q <= `PSS_TBLPTR_RESET;
        end else if (clk_en && apb_wr && paddr == `PSS_ADDR_TBLPTR) begin
            tbl_ptr_q <= pwdata[7:0];
        end
    end

    // Low byte write waits for the cycle end; a new write wins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pcl_pend_q <= 1'b0;
            pcl_data_q <= '0;
        end else if (clk_en) begin
            if (pcl_wr) begin
                pcl_pend_q <= 1'b1;
                pcl_data_q <= pwdata[7:0];
            end else if (cyc_end && !stall_q) begin
                pcl_pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_phase_wrap;
        cyc_end |=> phase_q == PSS_PH1 ##1 (phase_q == PSS_PH1 || $past(clk_en));
    endproperty
    a_phase_wrap: assert property (p_phase_wrap)
        else $error("phase did not wrap");

    property p_incr;
        cyc_end && !stall_q && !pcl_pend_q && !run && !take_irq
            |=> pc_q == $past(pc_q) + 12'h001;
    endproperty
    a_incr: assert property (p_incr)
        else $error("counter did not advance");

    property p_skip;
        cyc_end && !stall_q && !pcl_pend_q && run && cmd.op == PSS_OP_SKIP
            |=> pc_q == $past(pc_q) + 12'h001 && !exec_valid_q;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip kept fetched word");

    property p_jump;
        cyc_end && !stall_q && !pcl_pend_q && run && cmd.op == PSS_OP_JUMP
            |=> pc_q == $past(cmd.target) && prog_addr_q == pc_q && !exec_valid_q;
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target wrong");

    property p_pcl;
        cyc_end && !stall_q && pcl_pend_q
            |=> pc_q[11:8] == $past(pc_q[11:8]) && pc_q[7:0] == $past(pcl_data_q);
    endproperty
    a_pcl: assert property (p_pcl)
        else $error("low byte jump wrong");

    property p_vec_a;
        irq_ack_q[0] |-> pc_q == `PSS_VEC_A && gie_clear_q && $past(sp_q) != 3'd6;
    endproperty
    a_vec_a: assert property (p_vec_a)
        else $error("line a vector wrong");

    property p_full_hold;
        stack_full |-> !take_irq;
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("acknowledge with full stack");

    property p_depth;
        sp_q <= `PSS_STACK_LEVELS && $onehot0(irq_ack_q);
    endproperty
    a_depth: assert property (p_depth)
        else $error("stack depth out of range");

    property p_tab_two;
        cyc_end && start_tab |=> stall_q && !exec_valid_q;
    endproperty
    a_tab_two: assert property (p_tab_two)
        else $error("table read not stalled");

    property p_tblhi_top;
        prdata_q[31:7] == '0 || !$past(paddr == `PSS_ADDR_TBLHI && psel && !penable && clk_en);
    endproperty
    a_tblhi_top: assert property (p_tblhi_top)
        else $error("table high top bit set");

endmodule

// ==== sim/pss_prog_mem.sv ====
/*
 Program memory model for the sequencer bench: 4096 words of 15 bits.
 Assumes the bench fills the mem array directly before each run, and
 that the sequencer samples the word in the same cycle as the address.
*/
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_prog_mem
    import pss_pkg::*;
(
    input wire logic [`PSS_PC_W-1:0] addr,
    output logic [`PSS_WORD_W-1:0] data
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Whole address space, one word per counter value
    logic [`PSS_WORD_W-1:0] mem [0:4095];

    // Combinational answer: the sequencer needs it before cycle end
    assign data = mem[addr];
endmodule

// ==== sim/tb_top.sv ====
/*
 Bench of the program sequencer: decoder stub, memory model, APB
 master, interrupt source model and one task per scenario.
 Assumes the sequencer and the memory model are compiled before it.
*/
`timescale 1ns/1ps
`include "pss_defines.svh"
module tb_top
    import pss_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1; // High except during the freeze check
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] prog_addr_q;
    logic [14:0] prog_data;
    logic [14:0] instr_q;
    logic exec_valid_q;
    pss_cmd_t cmd;
    pss_phase_t phase_q;
    logic [7:0] tab_low_q;
    logic tab_low_stb_q;
    logic [5:0] irq_pending = 6'h00;
    logic global_irq_enable = 1'b0;
    logic [5:0] irq_ack_q;
    logic gie_clear_q;
    logic [5:0] ack_seen; // Last acknowledge seen, sticky
    logic ack_gie; // Enable-clear request seen with it
    logic [11:0] ack_addr; // Fetch address while acknowledging
    logic [31:0] rd; // Last APB read data
    logic er; // Last APB error flag
    int n_errors = 0;
    int n_checks = 0;

    always #50 ref_clk = ~ref_clk;

    // Decoder stub: top three bits pick the one-hot class
    assign cmd.op = pss_op_t'(8'h01 << instr_q[14:12]);
    assign cmd.target = instr_q[11:0];

    pss_sequencer dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr_q(prog_addr_q), .prog_data(prog_data), .instr_q(instr_q),
        .exec_valid_q(exec_valid_q), .cmd(cmd), .phase_q(phase_q),
        .tab_low_q(tab_low_q), .tab_low_stb_q(tab_low_stb_q),
        .irq_pending(irq_pending), .global_irq_enable(global_irq_enable),
        .irq_ack_q(irq_ack_q), .gie_clear_q(gie_clear_q));

    pss_prog_mem mem_u (.addr(prog_addr_q), .data(prog_data));

    // ------------------------------------------------------------
    // Interrupt source model
    // ------------------------------------------------------------
    // Holds the global enable outside the block, clears request flags
    // on acknowledge, and records each acknowledge for the scenarios
    always @(posedge ref_clk) begin
        if (reset) begin
            ack_seen <= 6'h00;
            ack_gie <= 1'b0;
            ack_addr <= 12'h000;
            global_irq_enable <= 1'b0;
        end else if (irq_ack_q !== 6'h00) begin
            ack_seen <= irq_ack_q;
            ack_gie <= gie_clear_q;
            ack_addr <= prog_addr_q;
            irq_pending <= irq_pending & ~irq_ack_q;
            if (gie_clear_q === 1'b1) begin
                global_irq_enable <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask

    // One instruction cycle: returns just after the next cycle end
    task automatic cyc();
        int i;
        i = 0;
        do begin
            @(posedge ref_clk);
            #1;
            i++;
        end while (phase_q !== PSS_PH1 && i < 8);
        if (i >= 8) begin
            n_errors++;
            summarize();
        end
    endtask

    // Clear memory, then hold reset for three clocks
    task automatic rst();
        int i;
        for (i = 0; i < 4096; i++) begin
            mem_u.mem[i] = 15'h0000;
        end
        @(posedge ref_clk);
        reset <= 1'b1;
        irq_pending <= 6'h00;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 16) begin
            n_errors++;
            summarize();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_reset();
        int i;
        rst();
        #1;
        chk(phase_q, PSS_PH1);
        chk(prog_addr_q, `PSS_PC_RESET);
        chk(exec_valid_q, 1'b0);
        for (i = 1; i <= 4; i++) begin
            @(posedge ref_clk);
            #1;
            chk(phase_q, 4'h1 << (i % 4));
        end
        chk(prog_addr_q, 12'h001);
        chk(exec_valid_q, 1'b1);
        // Enable low freezes the phase and the fetch address
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(phase_q, PSS_PH2);
        chk(prog_addr_q, 12'h001);
        @(posedge ref_clk);
        clk_en <= 1'b1;
    endtask

    task automatic s_skip();
        rst();
        mem_u.mem[1] = 15'h1000;
        mem_u.mem[3] = 15'h0222;
        repeat (3) cyc();
        chk(exec_valid_q, 1'b0);
        chk(prog_addr_q, 12'h003);
        cyc();
        chk(instr_q, 15'h0222);
    endtask

    // Full jump to another page, then a low byte write inside it
    task automatic s_jump();
        rst();
        mem_u.mem[1] = 15'h23f0;
        mem_u.mem[12'h3f0] = 15'h0abc;
        repeat (3) cyc();
        chk(prog_addr_q, 12'h3f0);
        chk(exec_valid_q, 1'b0);
        cyc();
        chk(instr_q, 15'h0abc);
        chk(prog_addr_q, 12'h3f1);
        apb(1'b1, `PSS_ADDR_PCL, 32'h0000_0045);
        cyc();
        chk(prog_addr_q, 12'h345);
        chk(exec_valid_q, 1'b0);
    endtask

    // Call then both kinds of return
    task automatic s_call();
        int t;
        for (t = 0; t < 2; t++) begin
            rst();
            mem_u.mem[1] = 15'h3200;
            mem_u.mem[12'h200] = (t == 1) ? 15'h5000 : 15'h4000;
            repeat (3) cyc();
            chk(prog_addr_q, 12'h200);
            repeat (2) cyc();
            chk(prog_addr_q, 12'h002);
            chk(exec_valid_q, 1'b0);
        end
    endtask

    // Current-page and last-page table reads from the same pointer
    task automatic s_table();
        int t;
        logic [14:0] w;
        logic [11:0] a;
        for (t = 0; t < 2; t++) begin
            rst();
            mem_u.mem[1] = (t == 1) ? 15'h7000 : 15'h6000;
            mem_u.mem[12'h080] = 15'h5abc;
            mem_u.mem[12'hf80] = 15'h2b3c;
            w = (t == 1) ? 15'h2b3c : 15'h5abc;
            a = (t == 1) ? 12'hf80 : 12'h080;
            apb(1'b1, `PSS_ADDR_TBLPTR, 32'h0000_0080);
            repeat (3) cyc();
            chk(prog_addr_q, a);
            chk(exec_valid_q, 1'b0);
            cyc();
            chk(tab_low_q, w[7:0]);
            chk(tab_low_stb_q, 1'b1);
            chk(exec_valid_q, 1'b1);
            apb(1'b1, `PSS_ADDR_TBLHI, 32'h0000_00ff);
            apb(1'b0, `PSS_ADDR_TBLHI, 32'h0000_0000);
            chk(rd, {25'h0, w[14:8]});
            apb(1'b0, 12'h03c, 32'h0000_0000);
            chk(er, 1'b1);
        end
    endtask

    // Every source in turn at the head of the pending set, all higher sources also pending
    task automatic s_irq();
        int b;
        int i;
        for (b = 0; b < 6; b++) begin
            rst();
            @(posedge ref_clk);
            irq_pending <= 6'h3f << b;
            repeat (3) cyc();
            chk(ack_seen, 6'h00);
            @(posedge ref_clk);
            global_irq_enable <= 1'b1;
            i = 0;
            while (ack_seen === 6'h00 && i < 8) begin
                cyc();
                i++;
            end
            chk(ack_seen, 6'h01 << b);
            chk(ack_addr, 12'h004 * (b + 1));
            chk(ack_gie, 1'b1);
        end
    endtask

    // Six nested calls fill the stack; a return frees a level
    task automatic s_full();
        int i;
        rst();
        for (i = 0; i < 6; i++) begin
            mem_u.mem[i] = {3'h3, 12'(i + 1)};
        end
        mem_u.mem[12'h010] = 15'h4000;
        repeat (14) cyc();
        @(posedge ref_clk);
        global_irq_enable <= 1'b1;
        irq_pending <= 6'h01;
        repeat (5) cyc();
        chk(ack_seen, 6'h00);
        i = 0;
        while (ack_seen === 6'h00 && i < 12) begin
            cyc();
            i++;
        end
        chk(ack_seen, 6'h01);
        chk(ack_addr, `PSS_VEC_A);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        s_reset();
        s_skip();
        s_jump();
        s_call();
        s_table();
        s_irq();
        s_full();
        summarize();
    end
endmodule
